// [design/csi_slave_defines.svh]
`ifndef CSI_SLAVE_DEFINES_SVH
`define CSI_SLAVE_DEFINES_SVH

`define AXI_AW 8
`define OFS_MODE 8'h00
`define OFS_SO_LEVEL 8'h04
`define OFS_SO_ENABLE 8'h08
`define OFS_P1_LATCH 8'h0C
`define OFS_P1_DIR 8'h10
`define OFS_IF_HIGH 8'h14
`define OFS_MK_HIGH 8'h18
`define OFS_START 8'h1C
`define OFS_STATUS 8'h20
`define OFS_DATA 8'h24
`define OFS_ALIAS 8'h28
`define OFS_EV_STAT 8'h2C
`define OFS_EV_MASK 8'h30
`define OFS_STOP 8'h34

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define BIT_XFER_END 5
`define BIT_TSF 6
`define BIT_START 0
`define PIN_SCK 0
`define PIN_SI 1
`define PIN_SO 2
`define EV_END 0
`define EV_REFUSED 1

`define DLS_7BIT 2'h2
`define DLS_8BIT 2'h3
`define LEN_7 4'h7
`define LEN_8 4'h8
`define TXRX_OFF 2'h0
`define TXRX_RX_ONLY 2'h1

`define MODE_RESET 6'h03
`define P1_LATCH_RESET 8'h00
`define P1_DIR_RESET 8'hFF
`define MASK_RESET 8'hFF
`define EV_MASK_RESET 2'h3

// Half period of the internal shift clock; a least time, so it rounds up
`define INT_HALF_NS 50
`define CLK_NS 5
`define INT_HALF_CYC ((`INT_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [design/csi_slave_pkg.sv]
package csi_slave_pkg;
	typedef enum logic [1:0] {CH_STOPPED, CH_WAIT, CH_SHIFT} chan_state_t;

	typedef struct packed {
		logic [1:0] txrx;
		logic bit_order_select;
		logic transfer_clock_select;
		logic [1:0] frame_length_sel;
	} chan_mode_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;
endpackage

// [design/csi_slave.sv]
// Notes on behaviour
// R1: Length field 10 gives 7-bit frame, 11 gives 8-bit; others never start.
// R2: Software never picks the 9-bit length in this mode.
// R3: Output level bit drives data output pin low for 0, high for 1.
// R4: With output drive disabled the pin simply shows the output level bit.
// R5: With output drive enabled the pin carries the shifted data during a frame; here only while transmit (enable pair bit 1) is on.
// R6: Direction bit 0 turns the pin driver on, 1 makes it an input.
// R7: Latch sets driven level; read in input mode returns the pin level.
// R8: Transfer-end flag at bit 5 shows a pending request; software clears it.
// R9: Transfer-end mask at bit 5 blocks the request from the interrupt when 1.
// R10: Start bit 1 enables the channel and waits for communication; 0 is ignored.
// R11: Start trigger register always reads zero.
// R12: Status bit 6 is high exactly while a frame is being shifted.
// R13: Writing low data byte loads transmit data and starts the frame.
// R14: Byte alias reaches the same low data byte.
// R15: Clock select 1 shifts on the pin clock, 0 on the internal divided clock.
// R16: Order bit 0 shifts most significant bit first, 1 least first.
// R17: Enable pair 00 off, 01 receive only, 10 transmit only, 11 both.
// R18: Frame end stores received bits, clears active flag, raises transfer-end flag.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "csi_slave_defines.svh"

module csi_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire csi_slave_pkg::axil_req_t axi_req,
	output csi_slave_pkg::axil_rsp_t axi_rsp,
	input wire logic [7:0] port_pin_in,
	output logic [7:0] port_pin_out,
	output logic [7:0] port_pin_oe_n,
	output logic irq
);
	import csi_slave_pkg::*;

	typedef struct packed {
		axil_rsp_t rsp;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		chan_mode_t mode;
		logic so_level;
		logic so_en;
		logic [7:0] p_latch;
		logic [7:0] p_dir;
		logic [7:0] if_h;
		logic [7:0] mk_h;
		logic ch_en;
		chan_state_t cst;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] data;
		logic [3:0] cnt;
		logic sck_prev;
		logic [7:0] div;
		logic int_sck;
		logic [1:0] ev_stat;
		logic [1:0] ev_mask;
		logic [7:0] pin_out;
		logic [7:0] pin_oe_n;
		logic irq;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	function automatic logic [3:0] frame_len(input logic [1:0] dls);
		frame_len = (dls == `DLS_7BIT) ? `LEN_7 : `LEN_8; // [R1]
	endfunction

	// Position in the byte of the bit handled at count c
	function automatic logic [2:0] bit_pos(input logic [3:0] c, input logic [1:0] dls,
			input logic lsb_first);
		logic [3:0] p;
		p = lsb_first ? c : frame_len(dls) - 4'h1 - c; // [R16]
		bit_pos = p[2:0];
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= `OFS_STOP);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] st);
		merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [31:0] rd_word(input state_t s, input logic [7:0] a,
			input logic [7:0] pins);
		rd_word = 32'h0000_0000;
		case (a)
			`OFS_MODE: rd_word[5:0] = s.mode;
			`OFS_SO_LEVEL: rd_word[0] = s.so_level;
			`OFS_SO_ENABLE: rd_word[0] = s.so_en;
			`OFS_P1_LATCH: rd_word[7:0] = (s.p_dir & pins) | (~s.p_dir & s.p_latch); // [R7]
			`OFS_P1_DIR: rd_word[7:0] = s.p_dir;
			`OFS_IF_HIGH: rd_word[7:0] = s.if_h;
			`OFS_MK_HIGH: rd_word[7:0] = s.mk_h;
			`OFS_STATUS: rd_word[`BIT_TSF] = (s.cst == CH_SHIFT); // [R12]
			`OFS_DATA, `OFS_ALIAS: rd_word[7:0] = s.data; // [R14]
			`OFS_EV_STAT: rd_word[1:0] = s.ev_stat;
			`OFS_EV_MASK: rd_word[1:0] = s.ev_mask;
			default: rd_word = 32'h0000_0000; // Start and stop triggers read zero [R11]
		endcase
	endfunction

	logic wr_fire;
	logic rd_fire;
	logic frame_end;
	assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.rsp.bvalid;
	assign rd_fire = axi_req.arvalid && s_r.rsp.arready;

	always_comb begin
		logic [15:0] m;
		logic sck;
		logic rise;
		logic [2:0] pos;
		logic so_val;
		logic txe;
		logic rxe;
		s_nxt = s_r;
		m = 16'h0000;
		sck = 1'b1;
		rise = 1'b0;
		pos = 3'h0;
		so_val = 1'b0;
		frame_end = 1'b0;
		txe = s_r.mode.txrx[1];
		rxe = s_r.mode.txrx[0];

		// Write address and data may arrive in either order
		if (axi_req.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s_r.rsp.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.w_data = axi_req.wdata;
			s_nxt.w_strb = axi_req.wstrb;
		end
		if (s_r.rsp.bvalid && axi_req.bready) begin
			s_nxt.rsp.bvalid = 1'b0;
		end
		if (s_r.rsp.rvalid && axi_req.rready) begin
			s_nxt.rsp.rvalid = 1'b0;
		end

		if (rd_fire) begin
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata = rd_word(s_r, axi_req.araddr, port_pin_in);
			s_nxt.rsp.rresp = addr_ok(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
			if (axi_req.araddr == `OFS_EV_STAT) begin
				s_nxt.ev_stat = 2'h0;
			end
		end

		if (wr_fire) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp = addr_ok(s_r.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			m = merge16(16'h0000, s_r.w_data, s_r.w_strb);
			case (s_r.aw_addr)
				`OFS_MODE: if (s_r.w_strb[0]) s_nxt.mode = m[5:0];
				`OFS_SO_LEVEL: if (s_r.w_strb[0]) s_nxt.so_level = m[0];
				`OFS_SO_ENABLE: if (s_r.w_strb[0]) s_nxt.so_en = m[0];
				`OFS_P1_LATCH: if (s_r.w_strb[0]) s_nxt.p_latch = m[7:0];
				`OFS_P1_DIR: if (s_r.w_strb[0]) s_nxt.p_dir = m[7:0];
				`OFS_IF_HIGH: if (s_r.w_strb[0]) s_nxt.if_h = m[7:0];
				`OFS_MK_HIGH: if (s_r.w_strb[0]) s_nxt.mk_h = m[7:0];
				`OFS_EV_MASK: if (s_r.w_strb[0]) s_nxt.ev_mask = m[1:0];
				`OFS_START: begin
					if (m[`BIT_START]) begin
						s_nxt.ch_en = 1'b1; // [R10]
						s_nxt.cst = CH_WAIT;
						s_nxt.cnt = 4'h0;
					end
				end
				`OFS_STOP: begin
					if (m[`BIT_START]) begin
						s_nxt.ch_en = 1'b0;
						s_nxt.cst = CH_STOPPED;
					end
				end
				`OFS_DATA, `OFS_ALIAS: begin
					if (s_r.w_strb[0]) begin
						// A write mid-frame would corrupt the shifter, so it is refused
						if (s_r.cst == CH_WAIT && s_r.mode.frame_length_sel[1] &&
								s_r.mode.txrx != `TXRX_OFF) begin
							s_nxt.tx = m[7:0]; // [R13] [R14]
							s_nxt.cst = CH_SHIFT;
							s_nxt.cnt = 4'h0;
							s_nxt.int_sck = 1'b1;
							s_nxt.div = 8'h00;
						end else begin
							s_nxt.ev_stat[`EV_REFUSED] = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Internal clock runs only while a frame is shifting
		if (s_r.cst == CH_SHIFT && !s_r.mode.transfer_clock_select) begin
			if (s_r.div == 8'(`INT_HALF_CYC - 1)) begin
				s_nxt.div = 8'h00;
				s_nxt.int_sck = !s_r.int_sck;
			end else begin
				s_nxt.div = s_r.div + 8'h01;
			end
		end
		sck = s_r.mode.transfer_clock_select ? port_pin_in[`PIN_SCK] : s_r.int_sck; // [R15]
		s_nxt.sck_prev = sck;
		rise = sck && !s_r.sck_prev;
		pos = bit_pos(s_r.cnt, s_r.mode.frame_length_sel, s_r.mode.bit_order_select);

		// Receive-only waits for the master's first edge, no data write needed
		if (rise && s_r.cst == CH_WAIT && s_r.mode.txrx == `TXRX_RX_ONLY &&
				s_r.mode.transfer_clock_select && s_r.mode.frame_length_sel[1]) begin
			s_nxt.cst = CH_SHIFT; // [R17]
			s_nxt.cnt = 4'h0;
		end
		if (rise && (s_r.cst == CH_SHIFT || s_nxt.cst == CH_SHIFT && s_r.cst == CH_WAIT &&
				s_r.mode.txrx == `TXRX_RX_ONLY)) begin
			if (rxe) begin
				s_nxt.rx[pos] = port_pin_in[`PIN_SI]; // [R17]
			end
			s_nxt.cnt = s_r.cnt + 4'h1;
			if (s_r.cnt + 4'h1 == frame_len(s_r.mode.frame_length_sel)) begin
				frame_end = 1'b1;
				s_nxt.data = s_nxt.rx;
				if (s_r.mode.frame_length_sel == `DLS_7BIT) begin
					s_nxt.data[7] = 1'b0; // [R1]
				end
				s_nxt.cst = CH_WAIT; // [R18]
				s_nxt.cnt = 4'h0;
			end
		end
		if (s_r.mode.txrx == `TXRX_OFF && s_r.cst == CH_SHIFT) begin
			s_nxt.cst = CH_WAIT; // [R17]
		end
		if (!s_nxt.ch_en) begin
			s_nxt.cst = CH_STOPPED;
		end

		// Hardware sets come last so they win over a same-cycle clear
		if (frame_end) begin
			s_nxt.if_h[`BIT_XFER_END] = 1'b1; // [R8] [R18]
			s_nxt.ev_stat[`EV_END] = 1'b1;
		end

		so_val = (s_nxt.so_en && txe && s_nxt.cst == CH_SHIFT) ? // [R5]
			s_nxt.tx[bit_pos(s_nxt.cnt, s_nxt.mode.frame_length_sel,
			s_nxt.mode.bit_order_select)] : s_nxt.so_level; // [R3] [R4]
		s_nxt.pin_out = s_nxt.p_latch; // [R7]
		s_nxt.pin_out[`PIN_SO] = s_nxt.p_latch[`PIN_SO] & so_val;
		s_nxt.pin_oe_n = s_nxt.p_dir; // [R6]
		s_nxt.irq = (s_nxt.if_h[`BIT_XFER_END] & ~s_nxt.mk_h[`BIT_XFER_END]) | // [R9]
			(|(s_nxt.ev_stat & ~s_nxt.ev_mask));

		s_nxt.rsp.awready = !s_nxt.aw_held && !s_nxt.rsp.bvalid;
		s_nxt.rsp.wready = !s_nxt.w_held && !s_nxt.rsp.bvalid;
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.mode <= `MODE_RESET;
			s_r.p_latch <= `P1_LATCH_RESET;
			s_r.p_dir <= `P1_DIR_RESET;
			s_r.pin_oe_n <= `P1_DIR_RESET;
			s_r.mk_h <= `MASK_RESET;
			s_r.ev_mask <= `EV_MASK_RESET;
			s_r.cst <= CH_STOPPED;
			s_r.sck_prev <= 1'b1;
			s_r.int_sck <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign axi_rsp = s_r.rsp;
	assign port_pin_out = s_r.pin_out;
	assign port_pin_oe_n = s_r.pin_oe_n;
	assign irq = s_r.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_start_enables_channel: assert property ( // [R10]
		wr_fire && s_r.aw_addr == `OFS_START && s_r.w_strb[0] && s_r.w_data[0]
		|=> s_r.ch_en && s_r.cst == CH_WAIT
	) else $error("start trigger did not enable channel");

	chk_start_reads_zero: assert property ( // [R11]
		rd_fire && axi_req.araddr == `OFS_START |=> s_r.rsp.rvalid && s_r.rsp.rdata == 32'h0000_0000
	) else $error("start trigger read not zero");

	chk_status_active_flag: assert property ( // [R12]
		rd_fire && axi_req.araddr == `OFS_STATUS
		|=> s_r.rsp.rdata[`BIT_TSF] == ($past(s_r.cst) == CH_SHIFT)
	) else $error("active flag disagrees with shifter");

	chk_frame_end_flag: assert property ( // [R18]
		frame_end |=> s_r.if_h[`BIT_XFER_END] && s_r.cst != CH_SHIFT && s_r.ev_stat[`EV_END]
	) else $error("frame end did not raise flag");

	chk_mask_blocks_irq: assert property ( // [R9]
		s_r.mk_h[`BIT_XFER_END] && s_r.ev_stat == 2'h0 |-> !irq
	) else $error("masked request reached irq");

	chk_unmasked_flag_irq: assert property ( // [R8]
		s_r.if_h[`BIT_XFER_END] && !s_r.mk_h[`BIT_XFER_END] |-> irq
	) else $error("pending request did not reach irq");

	chk_shift_drives_pin: assert property ( // [R5]
		s_r.so_en && s_r.mode.txrx[1] && s_r.cst == CH_SHIFT && s_r.p_latch[`PIN_SO]
		|-> port_pin_out[`PIN_SO] ==
			s_r.tx[bit_pos(s_r.cnt, s_r.mode.frame_length_sel, s_r.mode.bit_order_select)]
	) else $error("data pin not carrying shifted bit");

	chk_stop_halts_channel: assert property ( // [R10]
		wr_fire && s_r.aw_addr == `OFS_STOP && s_r.w_strb[0] && s_r.w_data[0]
		|=> !s_r.ch_en && s_r.cst == CH_STOPPED
	) else $error("stop trigger did not halt channel");

	chk_dir_drives_oe: assert property ( // [R6]
		port_pin_oe_n == s_r.p_dir
	) else $error("pin enable does not follow direction");

	chk_idle_so_level: assert property ( // [R4]
		(!s_r.so_en || s_r.cst != CH_SHIFT) && s_r.p_latch[`PIN_SO]
		|-> port_pin_out[`PIN_SO] == s_r.so_level
	) else $error("data pin not at level bit");

	chk_len7_top_clear: assert property ( // [R1]
		frame_end && s_r.mode.frame_length_sel == `DLS_7BIT |=> s_r.data[7] == 1'b0
	) else $error("7-bit frame set bit 7");

	chk_off_never_shifts: assert property ( // [R17]
		s_r.mode.txrx == `TXRX_OFF |=> s_r.cst != CH_SHIFT
	) else $error("shifting while communication off");

	chk_data_write_starts: assert property ( // [R13]
		wr_fire && s_r.aw_addr == `OFS_ALIAS && s_r.w_strb[0] && s_r.cst == CH_WAIT &&
		s_r.mode.frame_length_sel[1] && s_r.mode.txrx != `TXRX_OFF && s_r.ch_en
		|=> s_r.cst == CH_SHIFT && s_r.tx == $past(s_r.w_data[7:0])
	) else $error("data write did not start frame");
endmodule

// [verif/spi_master_model.sv]
`timescale 1ns/100ps
module spi_master_model (
	input wire logic aclk,
	input wire logic so,
	input wire logic go,
	input wire logic lsb,
	input wire logic [3:0] nb,
	input wire logic [7:0] tx,
	output logic sck,
	output logic si,
	output logic [7:0] rx,
	output logic busy
);
	int i;
	int k;
	initial begin
		sck = 1'b1;
		si = 1'b0;
		rx = 8'h00;
		busy = 1'b0;
	end
	// Clock idles high; data moves on the fall and is sampled just before the rise
	always @(posedge aclk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			rx <= 8'h00;
			for (i = 0; i < int'(nb); i++) begin
				k = lsb ? i : int'(nb) - 1 - i;
				sck <= 1'b0;
				si <= tx[k];
				repeat (4) @(posedge aclk);
				rx[k] <= so;
				sck <= 1'b1;
				repeat (4) @(posedge aclk);
			end
			// Released line must not keep showing the last bit
			si <= ~si;
			busy <= 1'b0;
		end
	end
endmodule

// [verif/csi_slave_tb_top.sv]
`timescale 1ns/100ps
`include "csi_slave_defines.svh"
module csi_slave_tb_top;
	import csi_slave_pkg::*;
	logic aclk;
	logic aresetn;
	axil_req_t req;
	axil_rsp_t rsp;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] oe_n;
	logic [7:0] ext;
	logic irq, sck, si, go, lsb, busy;
	logic [3:0] nb;
	logic [7:0] tx, mrx, mk;
	logic [31:0] seed, rd_d, t;
	logic [1:0] rsp_c, m;
	int failures;
	int n_compared;
	int c, n;
	assign pin_in = (oe_n & {ext[7:2], si, sck}) | (~oe_n & pin_out);
	csi_slave i_csi_slave (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .irq(irq));
	spi_master_model i_spi_master_model (.aclk(aclk), .so(pin_in[2]), .go(go), .lsb(lsb),
		.nb(nb), .tx(tx), .sck(sck), .si(si), .rx(mrx), .busy(busy));
	task automatic tally_and_finish();
		$display("Counts: compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tmo();
		failures++;
		$display("BAD wait expected handshake seen none");
		tally_and_finish();
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 100);
		rsp_c = rsp.bresp;
		req.bready <= 1'b0;
		if (n >= 100) tmo();
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge aclk);
		req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 100);
		rd_d = rsp.rdata;
		rsp_c = rsp.rresp;
		req.rready <= 1'b0;
		if (n >= 100) tmo();
		chk(nm, e, rd_d);
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		aresetn = 1'b0;
		req = '0;
		ext = 8'h00;
		go = 1'b0;
		lsb = 1'b0;
		nb = 4'h8;
		tx = 8'h00;
		seed = 32'h0000_4f79;
		failures = 0;
		n_compared = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`OFS_MODE, 32'h0000_0003, "mode");
		rc(`OFS_P1_DIR, 32'h0000_00FF, "direction");
		rc(`OFS_MK_HIGH, 32'h0000_00FF, "mask");
		rc(`OFS_IF_HIGH, 32'h0000_0000, "flags");
		rc(`OFS_STATUS, 32'h0000_0000, "status");
		rc(8'h3C, 32'h0000_0000, "unmapped data");
		chk("unmapped resp", 32'(`RESP_SLVERR), 32'(rsp_c));
		$display("reset values done");
		t = xs();
		ext <= t[7:0];
		wr(`OFS_P1_DIR, 32'h0000_00FB);
		wr(`OFS_P1_LATCH, 32'h0000_0004);
		for (c = 0; c < 2; c++) begin
			wr(`OFS_SO_LEVEL, 32'(c));
			repeat (2) @(posedge aclk);
			chk("pin out", 32'(c), 32'(pin_out[2]));
		end
		chk("oe_n", 32'h0000_00FB, 32'(oe_n));
		rc(`OFS_P1_LATCH, 32'({ext[7:3], 1'b1, si, sck}), "port read");
		$display("pin test done");
		wr(`OFS_SO_ENABLE, 32'h0000_0001);
		for (c = 0; c < 12; c++) begin
			t = xs();
			m = 2'(c / 4 + 1);
			mk = c[0] ? 8'hFF : 8'h7F;
			lsb <= c[1];
			nb <= c[0] ? 4'h8 : 4'h7;
			tx <= t[15:8];
			ext <= t[31:24];
			wr(`OFS_MODE, {26'h0, m, c[1], 1'b1, c[0] ? 2'h3 : 2'h2});
			wr(`OFS_IF_HIGH, 32'h0000_0000);
			wr(`OFS_MK_HIGH, c[2] ? 32'h0000_00FF : 32'h0000_00DF);
			wr(`OFS_START, 32'h0000_0001);
			wr(c[0] ? `OFS_DATA : `OFS_ALIAS, {24'h0, t[7:0]});
			rc(`OFS_STATUS, 32'h0000_0040, "active");
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (busy && n < 300);
			if (n >= 300) tmo();
			repeat (4) @(posedge aclk);
			if (m[1]) chk("master rx", 32'(t[7:0] & mk), 32'(mrx));
			chk("irq", 32'(!c[2]), 32'(irq));
			rc(`OFS_IF_HIGH, 32'h0000_0020, "end flag");
			rc(`OFS_STATUS, 32'h0000_0000, "idle");
			if (m[0]) rc(`OFS_DATA, 32'(tx & mk), "rx data");
			rc(`OFS_EV_STAT, 32'h0000_0001, "frame event");
			$display("frame %0d done", c);
		end
		// Internal divided clock: frame runs with no master edges
		wr(`OFS_IF_HIGH, 32'h0000_0000);
		wr(`OFS_MODE, 32'h0000_0023);
		wr(`OFS_START, 32'h0000_0001);
		wr(`OFS_DATA, 32'h0000_003C);
		repeat (200) @(posedge aclk);
		rc(`OFS_IF_HIGH, 32'h0000_0020, "internal end");
		rc(`OFS_STATUS, 32'h0000_0000, "internal idle");
		rc(`OFS_EV_STAT, 32'h0000_0001, "internal event");
		wr(`OFS_IF_HIGH, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0000_0000, 32'(irq));
		// Length field 01 is the prohibited setting; 9-bit is never chosen here
		wr(`OFS_MODE, 32'h0000_0035);
		wr(`OFS_START, 32'h0000_0001);
		rc(`OFS_START, 32'h0000_0000, "start reads");
		wr(`OFS_DATA, 32'h0000_00A5);
		rc(`OFS_STATUS, 32'h0000_0000, "bad length");
		rc(`OFS_EV_STAT, 32'h0000_0002, "refused");
		rc(`OFS_EV_STAT, 32'h0000_0000, "read clear");
		wr(`OFS_MODE, 32'h0000_0037);
		wr(`OFS_STOP, 32'h0000_0001);
		wr(`OFS_START, 32'h0000_0000);
		wr(`OFS_DATA, 32'h0000_005A);
		rc(`OFS_EV_STAT, 32'h0000_0002, "start zero");
		$display("refusal test done");
		tally_and_finish();
	end
endmodule
